/* test/bpc_reader.sv */
// Purpose: reader model that writes the word and asks for mode changes
// Assumes: requests are one-cycle pulses launched after a rising edge
// Notes: released values are inverted so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none

module bpc_reader (
	input wire logic clk_i, // tag clock
	output var logic wr_o, // word write pulse
	output var logic [15:0] word_o, // word value
	output var logic bap_req_o, // mode change pulse
	output var logic bap_val_o, // requested mode
	output var logic ulp_req_o, // ulp change pulse
	output var logic ulp_val_o // requested ulp
);
	// quiet at start
	initial begin
		wr_o = 1'b0;
		word_o = 16'h0000;
		bap_req_o = 1'b0;
		bap_val_o = 1'b0;
		ulp_req_o = 1'b0;
		ulp_val_o = 1'b0;
	end

	task automatic write_word(input logic [15:0] w);
		@(posedge clk_i);
		wr_o <= 1'b1;
		word_o <= w | {2'h0, w[12], 13'h0000};
		@(posedge clk_i);
		wr_o <= 1'b0;
		word_o <= ~w;
	endtask

	// one request for mode and ulp; the tag decides whether it is allowed
	task automatic ask(input logic b, input logic u);
		@(posedge clk_i);
		bap_req_o <= 1'b1;
		bap_val_o <= b;
		ulp_req_o <= 1'b1;
		ulp_val_o <= u;
		@(posedge clk_i);
		bap_req_o <= 1'b0;
		bap_val_o <= ~b;
		ulp_req_o <= 1'b0;
		ulp_val_o <= ~u;
	endtask
endmodule
`default_nettype wire

/* test/tb_bpc_top.sv */
// Purpose: self-checking bench for the battery power configuration word
// Assumes: MS_CYCLES cut to 4 so one blink frame fits in the run
// Notes: over-air traffic goes through the reader model
`timescale 1ns/1ps
`default_nettype none
`include "bpc_params.svh"

module tb_bpc_top;
	import bpc_pkg::*;
	localparam int MS = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 0, stb = 0, we = 0, nld = 0, sf = 0, bt = 0, tk = 0, st = 0;
	logic te = 0, ms = 0, spi = 0, ao = 1, io = 1;
	logic [7:0] adr = 0, cnt = 0;
	logic [3:0] sel = 0, alm = 0;
	logic [31:0] dat = 0, rdat;
	logic [15:0] nw = 0, cfg_o, rw;
	bpc_tag_state_t ts = TAG_SLEEP;
	logic ack, irq, aux, ito, dso, mut, lbh, battery_assisted_mode, ulp, rwr, rbq, rbv, ruq, ruv;
	logic [3:0] aln;
	logic [11:0] mv;
	int bad_count = 0, cmp_count = 0, seed = 50493, cyc_cnt = 0;
	int n, t, c, lows[4], ovl;

	bpc_top #(.MS_CYCLES(MS)) u_bpc_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_o(irq), .nvm_load_i(nld), .nvm_word_i(nw),
		.reader_cfg_wr_i(rwr), .reader_cfg_i(rw), .cfg_word_o(cfg_o),
		.tag_state_i(ts), .select_flag_i(sf), .booting_i(bt),
		.aux_event_o(aux), .idle_count_i(cnt), .idle_tick_i(tk),
		.idle_start_i(st), .idle_timeout_o(ito), .duty_sleep_o(dso),
		.total_en_i(te), .tag_msg_sent_i(ms), .muted_o(mut),
		.spi_cfg_i(spi), .alarms_out_i(ao), .io_out_en_i(io),
		.alarm_i(alm), .alarm_n_o(aln), .lbd_high_o(lbh), .lbd_mv_o(mv),
		.reader_bap_req_i(rbq), .reader_bap_val_i(rbv),
		.reader_ulp_req_i(ruq), .reader_ulp_val_i(ruv),
		.bap_mode_o(battery_assisted_mode), .ulp_o(ulp));

	bpc_reader u_bpc_reader (.clk_i(clk_i), .wr_o(rwr), .word_o(rw),
		.bap_req_o(rbq), .bap_val_o(rbv), .ulp_req_o(ruq), .ulp_val_o(ruv));

	// free-running clock, 4 ns
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// hang guard: blink frame dominates, about 34k cycles in all
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one classic wishbone cycle; waits for ack, unbounded
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		// no local limit: only the hang guard ends a stuck wait
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("ack", 1, ack);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(nm, e, q);
	endtask

	// unit ticks until the watched output shows; 0 if it never does
	task automatic ticks(input int w, input int mx, output int k);
		bit hit;
		k = 0;
		hit = 0;
		while (!hit && k < mx) begin
			@(posedge clk_i);
			tk <= 1'b1;
			k++;
			@(posedge clk_i);
			tk <= 1'b0;
			repeat (3) begin
				@(posedge clk_i);
				if (w == 0 ? ito === 1'b1 : w == 1 ? dso === 1'b0 : mut === 1'b0)
					hit = 1;
			end
		end
		if (!hit)
			k = 0;
	endtask

	task automatic pulse_start();
		@(posedge clk_i);
		st <= 1'b1;
		@(posedge clk_i);
		st <= 1'b0;
	endtask

	function automatic logic [15:0] mk(logic [1:0] x, logic ie, logic me,
		logic [2:0] sc, logic [5:0] mc, logic bk, logic lb, logic pm);
		return {x, ie, me, sc, mc, bk, lb, pm};
	endfunction

	function automatic logic exp_aux(logic [1:0] x, logic [2:0] s,
		logic f, logic b);
		case (x)
			2'h0: return s != 3'h0;
			2'h1: return s >= 3'h2;
			2'h2: return s >= 3'h4;
			default: return f && !b && s != 3'h0;
		endcase
	endfunction

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check("alarm rst", 4'hf, aln);
		rd("cfg rst", `BPC_OFS_CFG, 0);
		// boot load, then bus access and an unmapped read
		nw <= $random(seed);
		nld <= 1'b1;
		@(posedge clk_i);
		nld <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("boot word", nw, cfg_o);
		check("lbd mv", nw[1] ? `BPC_LBD_HIGH_MV : `BPC_LBD_LOW_MV, mv);
		check("lbd bit", nw[1], lbh);
		// value kept in a variable, the bus task owns dat
		t = $random(seed);
		wr(`BPC_OFS_CFG, t);
		rd("cfg", `BPC_OFS_CFG, {16'h0, t[15:0]});
		rd("unmapped", 8'h20, 0);
		$display("test registers done");
		// every condition code against every state
		for (c = 0; c < 4; c++) begin
			u_bpc_reader.write_word(mk(c[1:0], 0, 0, 0, 0, 0, 0, 0));
			for (int s = 0; s < 7; s++) begin
				@(posedge clk_i);
				ts <= bpc_tag_state_t'(s[2:0]);
				sf <= $random(seed);
				bt <= $random(seed);
				repeat (3) @(posedge clk_i);
				check("aux", exp_aux(c[1:0], s[2:0], sf, bt), aux);
			end
		end
		$display("test aux done");
		// idle timer on and off
		for (int e = 1; e >= 0; e--) begin
			cnt <= {$random(seed)} % 6;
			u_bpc_reader.write_word(mk(0, e[0], 0, 0, 0, 0, 0, 0));
			pulse_start();
			ticks(0, cnt + 3, n);
			check("idle ticks", e ? cnt + 1 : 0, n);
		end
		// refused mode change raises, masks and clears the interrupt
		wr(`BPC_OFS_CLEAR, 32'h1f);
		u_bpc_reader.ask(1'b1, 1'b1);
		repeat (2) @(posedge clk_i);
		check("bap refused", 0, {battery_assisted_mode, ulp});
		rd("status", `BPC_OFS_STATUS, 32'h8);
		check("irq off", 0, irq);
		wr(`BPC_OFS_IRQEN, 32'h8);
		check("irq on", 1, irq);
		wr(`BPC_OFS_IRQEN, 32'h0);
		check("irq mask", 0, irq);
		wr(`BPC_OFS_IRQEN, 32'h8);
		wr(`BPC_OFS_CLEAR, 32'h8);
		check("irq clr", 0, irq);
		u_bpc_reader.write_word(mk(0, 0, 0, 0, 0, 0, 0, 1));
		u_bpc_reader.ask(1'b1, 1'b1);
		repeat (2) @(posedge clk_i);
		rd("mode", `BPC_OFS_MODE, 32'h3);
		$display("test permit done");
		// duty cycle: off, longest, random code
		for (int k = 0; k < 3; k++) begin
			c = k == 0 ? 0 : k == 1 ? 7 : 1 + {$random(seed)} % 6;
			cnt <= 1 + {$random(seed)} % 3;
			u_bpc_reader.write_word(mk(0, 1, 0, c[2:0], 0, 0, 0, 1));
			pulse_start();
			ticks(0, 8, n);
			repeat (2) @(posedge clk_i);
			check("sleeping", c != 0, dso);
			if (c != 0) begin
				ticks(1, 300, n);
				check("sleep ticks", cnt * (1 << (c - 1)) + 1, n);
			end
		end
		$display("test duty done");
		// self mute after the message limit, released by the mute timer
		c = 1 + {$random(seed)} % 8;
		te <= 1'b1;
		u_bpc_reader.write_word(mk(0, 1, 1, 0, c[5:0], 0, 0, 1));
		for (int k = 1; k <= c; k++) begin
			check("muted early", 0, mut);
			@(posedge clk_i);
			ms <= 1'b1;
			@(posedge clk_i);
			ms <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		check("muted", 1, mut);
		ticks(2, cnt + 3, n);
		check("mute ticks", cnt + 1, n);
		$display("test mute done");
		// continuous alarms, then one full blink frame
		alm <= $random(seed);
		repeat (3) @(posedge clk_i);
		check("alarm level", 4'(~alm), aln);
		alm <= 4'hf;
		u_bpc_reader.write_word(mk(0, 0, 0, 0, 0, 1, 0, 1));
		// let the continuous level drain before the frame is counted
		repeat (2) @(posedge clk_i);
		ovl = 0;
		lows = '{0, 0, 0, 0};
		repeat (8000 * MS) begin
			@(posedge clk_i);
			for (int p = 0; p < 4; p++)
				lows[p] += (aln[p] === 1'b0);
			ovl += ($countones(~aln) > 1);
		end
		for (int p = 0; p < 4; p++)
			check("blink low", 40 * MS, lows[p]);
		check("overlap", 0, ovl);
		$display("test alarms done");
		complete_run();
	end
endmodule
`default_nettype wire

/* verilog/bpc_params.svh */
// Purpose: constants for the battery power configuration word block
// Assumes: word bit 0 of the printed layout is the msb (word[15])
// Notes: offsets are byte addresses on a 32-bit wishbone slave
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

// register byte offsets
`define BPC_OFS_CFG 8'h00
`define BPC_OFS_MODE 8'h04
`define BPC_OFS_STATUS 8'h08
`define BPC_OFS_CLEAR 8'h0c
`define BPC_OFS_IRQEN 8'h10
`define BPC_OFS_STATE 8'h14

// field positions in the 16-bit word (printed bit k sits at 15-k)
`define BPC_F_AUX_HI 15
`define BPC_F_AUX_LO 14
`define BPC_F_IDLE_EN 13
`define BPC_F_MUTE_EN 12
`define BPC_F_SLEEP_HI 11
`define BPC_F_SLEEP_LO 9
`define BPC_F_MSG_HI 8
`define BPC_F_MSG_LO 3
`define BPC_F_BLINK 2
`define BPC_F_LBD 1
`define BPC_F_PERMIT 0

// reset values
`define BPC_CFG_RST 16'h0000
`define BPC_MODE_RST 2'h0

// event bits in status, clear and enable
`define BPC_EV_IDLE 0
`define BPC_EV_MUTED 1
`define BPC_EV_SLEEP 2
`define BPC_EV_REFUSED 3
`define BPC_EV_UNMUTE 4
`define BPC_EV_W 5

// timing
`define BPC_CLK_KHZ 250000
`define BPC_BLINK_PULSE_MS 40
`define BPC_BLINK_PERIOD_MS 8000
`define BPC_BLINK_STAGGER_MS 1000

// low battery thresholds in millivolts
`define BPC_LBD_LOW_MV 12'h514
`define BPC_LBD_HIGH_MV 12'h898

`endif

/* verilog/bpc_pkg.sv */
// Purpose: types for the battery power configuration word block
// Assumes: bpc_params.svh holds every number
// Notes: tag state codes come from the protocol engine
`include "bpc_params.svh"

package bpc_pkg;

	// protocol engine state as seen by this block
	typedef enum logic [2:0] {
		TAG_SLEEP = 3'h0,
		TAG_READY = 3'h1,
		TAG_ARBITRATE = 3'h2,
		TAG_REPLY = 3'h3,
		TAG_ACKED = 3'h4,
		TAG_OPEN = 3'h5,
		TAG_SECURED = 3'h6
	} bpc_tag_state_t;

	// duty cycle sequencer, one-hot
	typedef enum logic [1:0] {
		DC_RUN = 2'b01,
		DC_SLEEP = 2'b10
	} bpc_duty_t;

	// whole state of the block
	typedef struct packed {
		logic [15:0] cfg;
		logic bap_mode;
		logic ulp;
		logic [`BPC_EV_W-1:0] status;
		logic [`BPC_EV_W-1:0] irq_en;
		logic ack;
		logic [31:0] rdata;
		logic aux;
		logic idle_run;
		logic [8:0] idle_cnt;
		logic idle_pulse;
		bpc_duty_t duty;
		logic [14:0] sleep_cnt;
		logic [5:0] msg_cnt;
		logic muted;
		logic mute_run;
		logic [8:0] mute_cnt;
		logic [19:0] ms_div;
		logic [12:0] blink_ms;
		logic [3:0] alarm_n;
	} bpc_state_t;

endpackage

/* verilog/bpc_top.sv */
// Purpose: battery power configuration word, decoded and applied
// Assumes: all inputs come from logic on clk_i; ticks are 1-cycle pulses
// Notes: word is held here and mirrored out for nonvolatile write-back
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_params.svh"

module bpc_top #(
	parameter int MS_CYCLES = `BPC_CLK_KHZ
) (
	input wire logic clk_i, // 250 MHz clock
	input wire logic rst_i, // sync reset, high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // one-cycle ack
	output logic irq_o, // level interrupt
	input wire logic nvm_load_i, // boot load of the word
	input wire logic [15:0] nvm_word_i, // word from storage
	input wire logic reader_cfg_wr_i, // over-air write of word
	input wire logic [15:0] reader_cfg_i, // over-air word value
	output logic [15:0] cfg_word_o, // word to store
	input wire bpc_pkg::bpc_tag_state_t tag_state_i, // protocol state
	input wire logic select_flag_i, // select flag
	input wire logic booting_i, // boot sequence busy
	output logic aux_event_o, // auxiliary event level
	input wire logic [7:0] idle_count_i, // idle timeout count
	input wire logic idle_tick_i, // idle unit period tick
	input wire logic idle_start_i, // restart idle timer
	output logic idle_timeout_o, // idle expiry pulse
	output logic duty_sleep_o, // duty-cycle sleeping
	input wire logic total_en_i, // broadcast mode on
	input wire logic tag_msg_sent_i, // broadcast message sent
	output logic muted_o, // self muted
	input wire logic spi_cfg_i, // serial peripheral mode
	input wire logic alarms_out_i, // alarm output selected
	input wire logic io_out_en_i, // io pins are outputs
	input wire logic [3:0] alarm_i, // alarm conditions
	output logic [3:0] alarm_n_o, // alarm pins, low active
	output logic lbd_high_o, // high threshold chosen
	output logic [11:0] lbd_mv_o, // threshold in mV
	input wire logic reader_bap_req_i, // reader sets mode
	input wire logic reader_bap_val_i, // requested mode
	input wire logic reader_ulp_req_i, // reader sets ulp
	input wire logic reader_ulp_val_i, // requested ulp
	output logic bap_mode_o, // battery_assisted_mode
	output logic ulp_o // ultra-low power enabled
);
	import bpc_pkg::*;

	bpc_state_t r;
	bpc_state_t n;

	// decoded fields
	logic [1:0] aux_cond;
	logic idle_en;
	logic mute_en;
	logic [2:0] sleep_code;
	logic [5:0] msg_limit;
	logic blink_en;
	logic permit;
	logic duty_en;
	logic mute_tout_en;
	logic alarm_ok;
	logic ms_tick;
	logic [14:0] sleep_load;
	logic bus_req;
	logic [`BPC_EV_W-1:0] ev;
	logic [`BPC_EV_W-1:0] clr;
	logic [12:0] slot;

	assign aux_cond = r.cfg[`BPC_F_AUX_HI:`BPC_F_AUX_LO];
	assign idle_en = r.cfg[`BPC_F_IDLE_EN];
	assign mute_en = r.cfg[`BPC_F_MUTE_EN];
	assign sleep_code = r.cfg[`BPC_F_SLEEP_HI:`BPC_F_SLEEP_LO];
	assign msg_limit = r.cfg[`BPC_F_MSG_HI:`BPC_F_MSG_LO];
	assign blink_en = r.cfg[`BPC_F_BLINK];
	assign permit = r.cfg[`BPC_F_PERMIT];

	assign duty_en = r.bap_mode && (idle_count_i != 8'h00) &&
		(sleep_code != 3'h0);
	// mute timeout only in broadcast mode
	assign mute_tout_en = total_en_i && mute_en;
	assign alarm_ok = !spi_cfg_i && alarms_out_i && io_out_en_i;
	assign ms_tick = (r.ms_div == 20'(MS_CYCLES - 1));
	// sleep count is idle count times 2^(code-1), plus one
	assign sleep_load = (15'(idle_count_i) << (sleep_code - 3'h1)) +
		15'h0001;
	assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;

	// write-one-to-clear strobe
	assign clr = (bus_req && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == `BPC_OFS_CLEAR) ? wb_dat_i[`BPC_EV_W-1:0] : '0;

	always_comb begin
		n = r;
		ev = '0;
		slot = 13'h0;
		n.ack = bus_req;
		n.idle_pulse = 1'b0;

		// wishbone writes, byte lanes honoured on the word
		if (bus_req && wb_we_i) begin
			case (wb_adr_i)
				`BPC_OFS_CFG: begin
					if (wb_sel_i[0])
						n.cfg[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1])
						n.cfg[15:8] = wb_dat_i[15:8];
				end
				`BPC_OFS_MODE: begin
					if (wb_sel_i[0]) begin
						n.bap_mode = wb_dat_i[0];
						n.ulp = wb_dat_i[1];
					end
				end
				`BPC_OFS_IRQEN: begin
					if (wb_sel_i[0])
						n.irq_en = wb_dat_i[`BPC_EV_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// over-air and boot loads win over the bus
		if (reader_cfg_wr_i)
			n.cfg = reader_cfg_i;
		if (nvm_load_i)
			n.cfg = nvm_word_i;

		// read mux, unmapped addresses read zero
		n.rdata = 32'h0;
		if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`BPC_OFS_CFG: n.rdata = {16'h0, r.cfg};
				`BPC_OFS_MODE: n.rdata = {30'h0, r.ulp, r.bap_mode};
				`BPC_OFS_STATUS: n.rdata = 32'(r.status);
				`BPC_OFS_IRQEN: n.rdata = 32'(r.irq_en);
				`BPC_OFS_STATE: n.rdata = {16'h0, 2'h0, r.msg_cnt,
					4'h0, r.duty == DC_SLEEP, r.muted, r.idle_run,
					r.aux};
				default: n.rdata = 32'h0;
			endcase
		end

		if (reader_bap_req_i || reader_ulp_req_i) begin
			if (permit) begin
				if (reader_bap_req_i)
					n.bap_mode = reader_bap_val_i;
				if (reader_ulp_req_i)
					n.ulp = reader_ulp_val_i;
			end else begin
				ev[`BPC_EV_REFUSED] = 1'b1;
			end
		end

		// aux event select, forced off in sleep; boot gates only code 11
		case (aux_cond)
			2'b00: n.aux = (tag_state_i != TAG_SLEEP);
			2'b01: n.aux = (tag_state_i == TAG_ARBITRATE) ||
				(tag_state_i == TAG_REPLY) ||
				(tag_state_i == TAG_ACKED) ||
				(tag_state_i == TAG_OPEN) ||
				(tag_state_i == TAG_SECURED);
			2'b10: n.aux = (tag_state_i == TAG_ACKED) ||
				(tag_state_i == TAG_OPEN) ||
				(tag_state_i == TAG_SECURED);
			2'b11: n.aux = select_flag_i &&
				(tag_state_i != TAG_SLEEP) && !booting_i;
			default: n.aux = 1'b0;
		endcase

		// load N+1, first tick lands within one period
		// idle timer runs only when enabled
		if (!idle_en) begin
			n.idle_run = 1'b0;
		end else if (idle_start_i && r.duty == DC_RUN) begin
			n.idle_run = 1'b1;
			n.idle_cnt = 9'(idle_count_i) + 9'h001;
		end else if (r.idle_run && idle_tick_i) begin
			n.idle_cnt = r.idle_cnt - 9'h001;
			if (r.idle_cnt == 9'h001) begin
				n.idle_run = 1'b0;
				n.idle_pulse = 1'b1;
				ev[`BPC_EV_IDLE] = 1'b1;
			end
		end

		case (r.duty)
			DC_RUN: begin
				if (n.idle_pulse && duty_en) begin
					n.duty = DC_SLEEP;
					n.sleep_cnt = sleep_load;
					ev[`BPC_EV_SLEEP] = 1'b1;
				end
			end
			DC_SLEEP: begin
				// leaving duty mode wakes at once
				if (!duty_en) begin
					n.duty = DC_RUN;
				end else if (idle_tick_i) begin
					n.sleep_cnt = r.sleep_cnt - 15'h0001;
					if (r.sleep_cnt == 15'h0001)
						n.duty = DC_RUN;
				end
			end
			default: n.duty = DC_RUN;
		endcase

		// count messages, mute at the limit; zero never mutes
		if (!total_en_i || msg_limit == 6'h00) begin
			n.muted = 1'b0;
			n.mute_run = 1'b0;
			n.msg_cnt = 6'h00;
		end else if (tag_msg_sent_i && !r.muted) begin
			n.msg_cnt = r.msg_cnt + 6'h01;
			if (r.msg_cnt + 6'h01 >= msg_limit) begin
				n.muted = 1'b1;
				ev[`BPC_EV_MUTED] = 1'b1;
				// mute timeout armed only when enabled
				n.mute_run = mute_tout_en;
				n.mute_cnt = 9'(idle_count_i) + 9'h001;
			end
		end else if (r.mute_run && !mute_tout_en) begin
			n.mute_run = 1'b0;
		end else if (r.mute_run && idle_tick_i) begin
			n.mute_cnt = r.mute_cnt - 9'h001;
			if (r.mute_cnt == 9'h001) begin
				n.mute_run = 1'b0;
				n.muted = 1'b0;
				n.msg_cnt = 6'h00;
				ev[`BPC_EV_UNMUTE] = 1'b1;
			end
		end

		// millisecond enable and 8 s blink frame
		n.ms_div = ms_tick ? 20'h0 : r.ms_div + 20'h1;
		if (ms_tick)
			n.blink_ms = (r.blink_ms == 13'(`BPC_BLINK_PERIOD_MS - 1)) ?
				13'h0 : r.blink_ms + 13'h1;

		// alarm pins, idle high when not in alarm output use
		for (int k = 0; k < 4; k++) begin
			slot = 13'(k * `BPC_BLINK_STAGGER_MS);
			if (!alarm_ok)
				n.alarm_n[k] = 1'b1;
			else if (!blink_en)
				n.alarm_n[k] = !alarm_i[k];
			else
				// each pin in its own slot
				n.alarm_n[k] = !(alarm_i[k] && r.blink_ms >= slot &&
					r.blink_ms < slot + 13'(`BPC_BLINK_PULSE_MS));
		end

		// sticky status, set wins over clear
		n.status = (r.status & ~clr) | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.cfg <= `BPC_CFG_RST;
			r.duty <= DC_RUN;
			r.alarm_n <= 4'hf;
		end else begin
			r <= n;
		end
	end

	// outputs
	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.rdata;
	assign irq_o = |(r.status & r.irq_en);
	assign cfg_word_o = r.cfg;
	assign aux_event_o = r.aux;
	assign idle_timeout_o = r.idle_pulse;
	assign duty_sleep_o = (r.duty == DC_SLEEP);
	assign muted_o = r.muted;
	assign alarm_n_o = r.alarm_n;
	assign lbd_high_o = r.cfg[`BPC_F_LBD];
	assign lbd_mv_o = r.cfg[`BPC_F_LBD] ? `BPC_LBD_HIGH_MV :
		`BPC_LBD_LOW_MV;
	assign bap_mode_o = r.bap_mode;
	assign ulp_o = r.ulp;

	// helper: idle ticks seen since the timer was armed
	logic [9:0] hv_ticks;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			hv_ticks <= 10'h0;
		else if (idle_start_i)
			hv_ticks <= 10'h0;
		else if (r.idle_run && idle_tick_i)
			hv_ticks <= hv_ticks + 10'h1;
	end

	property p_idle_window;
		@(posedge clk_i) disable iff (rst_i)
		(r.idle_run && idle_tick_i && r.idle_cnt == 9'h001 && idle_en &&
			!idle_start_i && $stable(idle_count_i)) |=>
			idle_timeout_o && hv_ticks == 10'(idle_count_i) + 10'h1;
	endproperty
	a_idle_window: assert property (p_idle_window)
		else $error("idle timeout not after N+1 ticks");

	property p_aux_present;
		@(posedge clk_i) disable iff (rst_i)
		(aux_cond == 2'b00) |=> aux_event_o == ($past(tag_state_i) !=
			TAG_SLEEP);
	endproperty
	a_aux_present: assert property (p_aux_present)
		else $error("aux wrong for field present");

	property p_aux_round;
		@(posedge clk_i) disable iff (rst_i)
		(aux_cond == 2'b01 && (tag_state_i == TAG_READY ||
			tag_state_i == TAG_SLEEP)) |=> !aux_event_o;
	endproperty
	a_aux_round: assert property (p_aux_round)
		else $error("aux high outside inventory round");

	property p_aux_single;
		@(posedge clk_i) disable iff (rst_i)
		(aux_cond == 2'b10) |=> aux_event_o ==
			($past(tag_state_i) >= TAG_ACKED);
	endproperty
	a_aux_single: assert property (p_aux_single)
		else $error("aux wrong for singulated");

	property p_aux_gate;
		@(posedge clk_i) disable iff (rst_i)
		(aux_cond == 2'b11 && (booting_i || tag_state_i == TAG_SLEEP))
			|=> !aux_event_o;
	endproperty
	a_aux_gate: assert property (p_aux_gate)
		else $error("aux not gated in sleep or boot");

	property p_idle_off;
		@(posedge clk_i) disable iff (rst_i)
		!idle_en |=> !idle_timeout_o ##1 !idle_timeout_o;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("idle timeout while disabled");

	property p_mute_hold;
		@(posedge clk_i) disable iff (rst_i)
		(muted_o && total_en_i && !mute_en && msg_limit != 6'h00) |=>
			muted_o;
	endproperty
	a_mute_hold: assert property (p_mute_hold)
		else $error("unmuted with mute timeout off");

	property p_no_duty;
		@(posedge clk_i) disable iff (rst_i)
		(sleep_code == 3'h0) |=> !duty_sleep_o;
	endproperty
	a_no_duty: assert property (p_no_duty)
		else $error("sleeping with duty cycle off");

	property p_mute_count;
		@(posedge clk_i) disable iff (rst_i)
		(total_en_i && tag_msg_sent_i && !muted_o && msg_limit != 6'h00
			&& r.msg_cnt + 6'h01 == msg_limit) |=> muted_o;
	endproperty
	a_mute_count: assert property (p_mute_count)
		else $error("not muted at message limit");

	property p_alarm_level;
		@(posedge clk_i) disable iff (rst_i)
		(alarm_ok && !blink_en) |=> alarm_n_o == ~$past(alarm_i);
	endproperty
	a_alarm_level: assert property (p_alarm_level)
		else $error("alarm level not continuous");

	property p_stagger;
		@(posedge clk_i) disable iff (rst_i)
		(alarm_ok && blink_en) |=> $onehot0(~alarm_n_o);
	endproperty
	a_stagger: assert property (p_stagger)
		else $error("two blink pulses at once");

	property p_refuse;
		@(posedge clk_i) disable iff (rst_i)
		(!permit && reader_bap_req_i && !(bus_req && wb_we_i)) |=>
			$stable(bap_mode_o) && status_refused();
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("mode change taken without permit");

	function automatic logic status_refused();
		return r.status[`BPC_EV_REFUSED];
	endfunction

endmodule
`default_nettype wire
